//--- csf_pkg.sv
// Constants shared by the processor status flag block and its register bus.
package csf_pkg;
    // Register bus geometry.
    localparam int ADDR_W = 4;
    localparam int DATA_W = 32;

    // Byte addresses of the word registers.
    localparam logic [3:0] OFS_STATUS = 4'h0;
    localparam logic [3:0] OFS_CORE_CTRL = 4'h4;
    localparam logic [3:0] OFS_INT_CTRL1 = 4'h8;
    localparam logic [3:0] OFS_EFF_LEVEL = 4'hC;

    // Register indices.
    localparam logic [1:0] IDX_STATUS = 2'h0;
    localparam logic [1:0] IDX_CORE_CTRL = 2'h1;
    localparam logic [1:0] IDX_INT_CTRL1 = 2'h2;
    localparam logic [1:0] IDX_EFF_LEVEL = 2'h3;

    // Status word field positions; the affect mask uses the same order.
    localparam int BIT_C = 0;
    localparam int BIT_Z = 1;
    localparam int BIT_SW = 2;
    localparam int BIT_N = 3;
    localparam int BIT_RA = 4;
    localparam int BIT_IPL_LO = 5;
    localparam int BIT_IPL_HI = 7;

    // Control word and effective-level word field positions.
    localparam int BIT_TOP = 3;
    localparam int BIT_NEST_OFF = 15;
    localparam int BIT_BLOCKED = 4;

    // Reset values.
    localparam logic [2:0] RST_IPL = 3'h0;
    localparam logic RST_FLAG = 1'b0;

    // Level that blocks user interrupts.
    localparam logic [2:0] IPL_MAX = 3'h7;

    // Bus responses.
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

//--- csf_status_flags.sv
// Processor status flags with an AXI4-Lite register slave.
`timescale 1ns/1ps
module csf_status_flags #(
    parameter int DW = 16
) (
    input wire logic ref_clk_i,
    input wire logic resetn_i,
    input wire logic ce_i,
    // Execution datapath.
    input wire logic flag_upd_i,
    input wire logic [3:0] flag_aff_i,
    input wire logic [DW-1:0] result_i,
    input wire logic carry_i,
    input wire logic sign_wrap_i,
    input wire logic zero_sticky_i,
    input wire logic repeat_active_i,
    input wire logic ipl_load_i,
    input wire logic [2:0] ipl_val_i,
    // Flag outputs.
    output logic [15:0] status_word_o,
    output logic [3:0] eff_level_o,
    output logic user_irq_blocked_o,
    // AXI4-Lite slave.
    input wire logic [csf_pkg::ADDR_W-1:0] s_axi_awaddr_i,
    input wire logic s_axi_awvalid_i,
    output logic s_axi_awready_o,
    input wire logic [csf_pkg::DATA_W-1:0] s_axi_wdata_i,
    input wire logic [3:0] s_axi_wstrb_i,
    input wire logic s_axi_wvalid_i,
    output logic s_axi_wready_o,
    output logic [1:0] s_axi_bresp_o,
    output logic s_axi_bvalid_o,
    input wire logic s_axi_bready_i,
    input wire logic [csf_pkg::ADDR_W-1:0] s_axi_araddr_i,
    input wire logic s_axi_arvalid_i,
    output logic s_axi_arready_o,
    output logic [csf_pkg::DATA_W-1:0] s_axi_rdata_o,
    output logic [1:0] s_axi_rresp_o,
    output logic s_axi_rvalid_o,
    input wire logic s_axi_rready_i
);

    // Channel holder states.
    typedef enum logic [1:0] {
        CSF_WR_IDLE = 2'b00,
        CSF_WR_EXEC = 2'b01,
        CSF_WR_RESP = 2'b10
    } csf_wr_t;

    logic [2:0] ipl_ff;
    logic ra_ff;
    logic n_ff;
    logic sw_ff;
    logic z_ff;
    logic c_ff;
    logic top_ff;
    logic nest_ff;
    logic [2:0] nxt_ipl;
    logic nxt_n;
    logic nxt_sw;
    logic nxt_z;
    logic nxt_c;

    csf_wr_t wr_ff;
    logic awgot_ff;
    logic wgot_ff;
    logic [csf_pkg::ADDR_W-1:0] awaddr_ff;
    logic [csf_pkg::DATA_W-1:0] wdata_ff;
    logic [3:0] wstrb_ff;
    logic [1:0] bresp_ff;
    logic rvalid_ff;
    logic [csf_pkg::DATA_W-1:0] rdata_ff;
    logic [1:0] rresp_ff;

    logic [2:0] wsel;
    logic [2:0] rsel;
    logic sw_we;
    logic we_status;
    logic we_core;
    logic we_int;
    logic upd;

    // Decode a byte address into {hit, index}; only aligned words hit.
    function automatic logic [2:0] reg_sel(
        input logic [csf_pkg::ADDR_W-1:0] addr
    );
        logic [2:0] s;
        s = 3'h0;
        case (addr)
            csf_pkg::OFS_STATUS: s = {1'b1, csf_pkg::IDX_STATUS};
            csf_pkg::OFS_CORE_CTRL: s = {1'b1, csf_pkg::IDX_CORE_CTRL};
            csf_pkg::OFS_INT_CTRL1: s = {1'b1, csf_pkg::IDX_INT_CTRL1};
            csf_pkg::OFS_EFF_LEVEL: s = {1'b1, csf_pkg::IDX_EFF_LEVEL};
            default: s = 3'h0;
        endcase
        return s;
    endfunction

    // Flag outputs come straight from the flip-flops.
    always_comb begin
        status_word_o = 16'h0000;
        status_word_o[csf_pkg::BIT_IPL_HI:csf_pkg::BIT_IPL_LO] = ipl_ff;
        status_word_o[csf_pkg::BIT_RA] = ra_ff;
        status_word_o[csf_pkg::BIT_N] = n_ff;
        status_word_o[csf_pkg::BIT_SW] = sw_ff;
        status_word_o[csf_pkg::BIT_Z] = z_ff;
        status_word_o[csf_pkg::BIT_C] = c_ff;
    end

    // Effective level joins the top bit above the three-bit field.
    assign eff_level_o = {top_ff, ipl_ff};
    assign user_irq_blocked_o = top_ff
        | (ipl_ff == csf_pkg::IPL_MAX);

    // Write strobes; a write runs one cycle after both halves are in.
    assign wsel = reg_sel(awaddr_ff);
    assign sw_we = (wr_ff == CSF_WR_EXEC) && wsel[2];
    assign we_status = sw_we && (wsel[1:0] == csf_pkg::IDX_STATUS);
    assign we_core = sw_we && (wsel[1:0] == csf_pkg::IDX_CORE_CTRL);
    assign we_int = sw_we && (wsel[1:0] == csf_pkg::IDX_INT_CTRL1);
    assign upd = flag_upd_i;

    // Next flag values. The datapath wins over a software write in the
    // same cycle, so a result is never lost to a late store.
    always_comb begin
        nxt_ipl = ipl_ff;
        nxt_n = n_ff;
        nxt_sw = sw_ff;
        nxt_z = z_ff;
        nxt_c = c_ff;
        if (we_status && wstrb_ff[0]) begin
            if (!nest_ff) begin
                nxt_ipl = wdata_ff[csf_pkg::BIT_IPL_HI:
                                   csf_pkg::BIT_IPL_LO];
            end
            nxt_n = wdata_ff[csf_pkg::BIT_N];
            nxt_sw = wdata_ff[csf_pkg::BIT_SW];
            nxt_z = wdata_ff[csf_pkg::BIT_Z];
            nxt_c = wdata_ff[csf_pkg::BIT_C];
        end
        if (ipl_load_i) begin
            nxt_ipl = ipl_val_i;
        end
        if (upd && flag_aff_i[csf_pkg::BIT_N]) begin
            nxt_n = result_i[DW-1];
        end
        if (upd && flag_aff_i[csf_pkg::BIT_SW]) begin
            nxt_sw = sign_wrap_i;
        end
        if (upd && flag_aff_i[csf_pkg::BIT_Z]) begin
            // A zero result under the sticky form leaves the flag alone.
            if (result_i != '0) begin
                nxt_z = 1'b0;
            end else if (!zero_sticky_i) begin
                nxt_z = 1'b1;
            end
        end
        if (upd && flag_aff_i[csf_pkg::BIT_C]) begin
            nxt_c = carry_i;
        end
    end

    // Status word flip-flops.
    always_ff @(posedge ref_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            ipl_ff <= csf_pkg::RST_IPL;
            n_ff <= csf_pkg::RST_FLAG;
            sw_ff <= csf_pkg::RST_FLAG;
            z_ff <= csf_pkg::RST_FLAG;
            c_ff <= csf_pkg::RST_FLAG;
        end else if (ce_i) begin
            ipl_ff <= nxt_ipl;
            n_ff <= nxt_n;
            sw_ff <= nxt_sw;
            z_ff <= nxt_z;
            c_ff <= nxt_c;
        end
    end

    // Repeat-active is status only and ignores software writes.
    always_ff @(posedge ref_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            ra_ff <= csf_pkg::RST_FLAG;
        end else if (ce_i) begin
            ra_ff <= repeat_active_i;
        end
    end

    // Control bits held on behalf of the core and interrupt controller.
    always_ff @(posedge ref_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            top_ff <= csf_pkg::RST_FLAG;
            nest_ff <= csf_pkg::RST_FLAG;
        end else if (ce_i) begin
            if (we_core && wstrb_ff[0]) begin
                top_ff <= wdata_ff[csf_pkg::BIT_TOP];
            end
            if (we_int && wstrb_ff[1]) begin
                nest_ff <= wdata_ff[csf_pkg::BIT_NEST_OFF];
            end
        end
    end

    // Write channels are taken in either order and held until executed.
    assign s_axi_awready_o = (wr_ff == CSF_WR_IDLE) && !awgot_ff;
    assign s_axi_wready_o = (wr_ff == CSF_WR_IDLE) && !wgot_ff;
    assign s_axi_bvalid_o = (wr_ff == CSF_WR_RESP);
    assign s_axi_bresp_o = bresp_ff;

    always_ff @(posedge ref_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            wr_ff <= CSF_WR_IDLE;
            awgot_ff <= 1'b0;
            wgot_ff <= 1'b0;
            awaddr_ff <= '0;
            wdata_ff <= '0;
            wstrb_ff <= 4'h0;
            bresp_ff <= csf_pkg::RESP_OKAY;
        end else if (ce_i) begin
            case (wr_ff)
                CSF_WR_IDLE: begin
                    if (s_axi_awvalid_i && s_axi_awready_o) begin
                        awaddr_ff <= s_axi_awaddr_i;
                        awgot_ff <= 1'b1;
                    end
                    if (s_axi_wvalid_i && s_axi_wready_o) begin
                        wdata_ff <= s_axi_wdata_i;
                        wstrb_ff <= s_axi_wstrb_i;
                        wgot_ff <= 1'b1;
                    end
                    if (awgot_ff && wgot_ff) begin
                        wr_ff <= CSF_WR_EXEC;
                    end
                end
                CSF_WR_EXEC: begin
                    // Unmapped addresses store nothing and report an error.
                    bresp_ff <= wsel[2] ? csf_pkg::RESP_OKAY
                                        : csf_pkg::RESP_SLVERR;
                    wr_ff <= CSF_WR_RESP;
                end
                CSF_WR_RESP: begin
                    if (s_axi_bready_i) begin
                        awgot_ff <= 1'b0;
                        wgot_ff <= 1'b0;
                        wr_ff <= CSF_WR_IDLE;
                    end
                end
                default: begin
                    wr_ff <= CSF_WR_IDLE;
                end
            endcase
        end
    end

    // Read data for a decoded index; reserved bits read as zero.
    function automatic logic [csf_pkg::DATA_W-1:0] rd_word(
        input logic [1:0] idx
    );
        logic [csf_pkg::DATA_W-1:0] d;
        d = '0;
        case (idx)
            csf_pkg::IDX_STATUS: d[15:0] = status_word_o;
            csf_pkg::IDX_CORE_CTRL: d[csf_pkg::BIT_TOP] = top_ff;
            csf_pkg::IDX_INT_CTRL1: d[csf_pkg::BIT_NEST_OFF] = nest_ff;
            csf_pkg::IDX_EFF_LEVEL: begin
                d[3:0] = eff_level_o;
                d[csf_pkg::BIT_BLOCKED] = user_irq_blocked_o;
            end
            default: d = '0;
        endcase
        return d;
    endfunction

    // Reads answer one cycle after the address is taken.
    assign rsel = reg_sel(s_axi_araddr_i);
    assign s_axi_arready_o = !rvalid_ff;
    assign s_axi_rvalid_o = rvalid_ff;
    assign s_axi_rdata_o = rdata_ff;
    assign s_axi_rresp_o = rresp_ff;

    always_ff @(posedge ref_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            rvalid_ff <= 1'b0;
            rdata_ff <= '0;
            rresp_ff <= csf_pkg::RESP_OKAY;
        end else if (ce_i) begin
            if (s_axi_arvalid_i && !rvalid_ff) begin
                rvalid_ff <= 1'b1;
                rdata_ff <= rsel[2] ? rd_word(rsel[1:0]) : '0;
                rresp_ff <= rsel[2] ? csf_pkg::RESP_OKAY
                                    : csf_pkg::RESP_SLVERR;
            end else if (rvalid_ff && s_axi_rready_i) begin
                rvalid_ff <= 1'b0;
            end
        end
    end

    // Checks on the flag behaviour.
    default clocking cb @(posedge ref_clk_i);
    endclocking
    default disable iff (!resetn_i);

    AST_LEVEL_MAX: assert property (
        (ipl_ff == csf_pkg::IPL_MAX) |-> user_irq_blocked_o)
        else $error("Level seven does not block user interrupts.");

    AST_TOP_BLOCK: assert property (
        (!top_ff && ipl_ff != csf_pkg::IPL_MAX) == !user_irq_blocked_o)
        else $error("Blocking does not follow the effective level.");

    AST_NEST_RO: assert property (
        ce_i && we_status && nest_ff && !ipl_load_i
        |=> ipl_ff == $past(ipl_ff))
        else $error("Priority field changed while nesting is off.");

    AST_REPEAT: assert property (
        ce_i ##1 ce_i |-> status_word_o[csf_pkg::BIT_RA]
        == $past(repeat_active_i))
        else $error("Repeat-active bit does not follow the loop.");

    AST_NEG: assert property (
        ce_i && upd && flag_aff_i[csf_pkg::BIT_N]
        |=> n_ff == $past(result_i[DW-1]))
        else $error("Negative flag does not follow the result sign.");

    AST_WRAP: assert property (
        ce_i && upd && flag_aff_i[csf_pkg::BIT_SW]
        |=> sw_ff == $past(sign_wrap_i))
        else $error("Sign-wrap flag does not follow overflow.");

    AST_ZCLR: assert property (
        ce_i && upd && flag_aff_i[csf_pkg::BIT_Z] && result_i != '0
        |=> !z_ff)
        else $error("Non-zero result left the zero flag set.");

    AST_ZSTICK: assert property (
        ce_i && upd && flag_aff_i[csf_pkg::BIT_Z] && z_ff
        && zero_sticky_i && result_i == '0 |=> z_ff)
        else $error("Sticky zero flag was lost.");

    AST_CARRY: assert property (
        ce_i && upd && flag_aff_i[csf_pkg::BIT_C]
        |=> c_ff == $past(carry_i))
        else $error("Carry flag does not follow the carry out.");

    AST_HOLD: assert property (
        ce_i && !we_status && !(upd && flag_aff_i[csf_pkg::BIT_C])
        |=> $stable(c_ff))
        else $error("Unaffected carry flag changed.");

    AST_FREEZE: assert property (
        !ce_i |=> $stable(status_word_o) && $stable(wr_ff))
        else $error("State moved while the clock enable was low.");

    CVR_NEST_BLOCK: cover property (ce_i && we_status && nest_ff);
    CVR_Z_STICK: cover property (
        ce_i && upd && zero_sticky_i && z_ff && result_i == '0);
    CVR_TOP_SET: cover property (top_ff && ipl_ff != csf_pkg::IPL_MAX);
    CVR_READ: cover property (s_axi_rvalid_o && s_axi_rready_i);

endmodule

//--- csf_dp_model.sv
// Behavioural model of the execution datapath that feeds the flag block.
`timescale 1ns/1ps
module csf_dp_model (
    input wire logic clk_i,
    output logic upd_o,
    output logic [3:0] aff_o,
    output logic [15:0] result_o,
    output logic carry_o,
    output logic wrap_o,
    output logic sticky_o,
    output logic rpt_o,
    output logic ipl_ld_o,
    output logic [2:0] ipl_val_o
);
    // Quiet values at time zero, so nothing is offered during reset.
    initial begin
        upd_o = 1'b0;
        aff_o = 4'h0;
        result_o = 16'h0000;
        carry_o = 1'b0;
        wrap_o = 1'b0;
        sticky_o = 1'b0;
        rpt_o = 1'b0;
        ipl_ld_o = 1'b0;
        ipl_val_o = 3'h0;
    end

    // One operation held for a single edge. The operands then flip so a
    // stale value is never mistaken for a flag the block kept by itself.
    task automatic op(input logic [3:0] aff, input logic [15:0] res,
                      input logic c, input logic wr, input logic zs);
        @(posedge clk_i);
        upd_o <= 1'b1;
        aff_o <= aff;
        result_o <= res;
        carry_o <= c;
        wrap_o <= wr;
        sticky_o <= zs;
        @(posedge clk_i);
        upd_o <= 1'b0;
        aff_o <= ~aff;
        result_o <= ~res;
        carry_o <= ~c;
        wrap_o <= ~wr;
    endtask

    // Exception entry loads the priority field for one edge.
    task automatic load_ipl(input logic [2:0] v);
        @(posedge clk_i);
        ipl_ld_o <= 1'b1;
        ipl_val_o <= v;
        @(posedge clk_i);
        ipl_ld_o <= 1'b0;
        ipl_val_o <= ~v;
    endtask

    // The sequencer reports whether a repeat loop is running.
    task automatic set_rpt(input logic v);
        @(posedge clk_i);
        rpt_o <= v;
    endtask
endmodule

//--- tb_cpu_status_flags.sv
// Self-checking bench for the status flag block and its register slave.
`timescale 1ns/1ps
module tb_cpu_status_flags;
    logic ref_clk, resetn, ce, upd, carry, wrap, sticky, rpt, ipl_ld;
    logic [3:0] aff, eff_level, awaddr, araddr, wstrb;
    logic [15:0] result, status_word;
    logic [2:0] ipl_val;
    logic blocked, awvalid, awready, wvalid, wready, bvalid, bready;
    logic arvalid, arready, rvalid, rready;
    logic [31:0] wdata, rdata;
    logic [1:0] bresp, rresp;
    int err_total = 0;
    int check_count = 0;
    logic [1:0] resp_v;
    logic [31:0] data_v;

    csf_dp_model dp (.clk_i(ref_clk), .upd_o(upd), .aff_o(aff),
        .result_o(result), .carry_o(carry), .wrap_o(wrap),
        .sticky_o(sticky), .rpt_o(rpt), .ipl_ld_o(ipl_ld),
        .ipl_val_o(ipl_val));

    csf_status_flags uut (.ref_clk_i(ref_clk), .resetn_i(resetn),
        .ce_i(ce), .flag_upd_i(upd), .flag_aff_i(aff), .result_i(result),
        .carry_i(carry), .sign_wrap_i(wrap), .zero_sticky_i(sticky),
        .repeat_active_i(rpt), .ipl_load_i(ipl_ld), .ipl_val_i(ipl_val),
        .status_word_o(status_word), .eff_level_o(eff_level),
        .user_irq_blocked_o(blocked), .s_axi_awaddr_i(awaddr),
        .s_axi_awvalid_i(awvalid), .s_axi_awready_o(awready),
        .s_axi_wdata_i(wdata), .s_axi_wstrb_i(wstrb),
        .s_axi_wvalid_i(wvalid), .s_axi_wready_o(wready),
        .s_axi_bresp_o(bresp), .s_axi_bvalid_o(bvalid),
        .s_axi_bready_i(bready), .s_axi_araddr_i(araddr),
        .s_axi_arvalid_i(arvalid), .s_axi_arready_o(arready),
        .s_axi_rdata_o(rdata), .s_axi_rresp_o(rresp),
        .s_axi_rvalid_o(rvalid), .s_axi_rready_i(rready));

    // Free-running 25 MHz clock.
    initial begin
        ref_clk = 1'b0;
        forever #20 ref_clk = ~ref_clk;
    end

    task automatic tally_and_finish();
        $display("Checks %0d, mismatches %0d", check_count, err_total);
        if (err_total == 0 && check_count > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    task automatic chk_w(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            err_total++;
            $display("[ERR] %0t data %h, expected %h", $time, got, exp);
        end
    endtask

    task automatic chk_r(input logic [1:0] got, input logic [1:0] exp);
        check_count++;
        if (got !== exp) begin
            err_total++;
            $display("[ERR] %0t response %h, expected %h", $time, got, exp);
        end
    endtask

    // Ready is looked at on the falling edge, so each channel is released
    // right after the rising edge that really took it.
    task automatic axi_wr(input logic [3:0] a, input logic [31:0] d,
                          output logic [1:0] r);
        int n;
        logic aw_d, w_d, b_d;
        n = 0;
        aw_d = 1'b0;
        w_d = 1'b0;
        b_d = 1'b0;
        @(posedge ref_clk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        while (!b_d && n < 40) begin
            @(negedge ref_clk);
            aw_d = aw_d | (awvalid & (awready === 1'b1));
            w_d = w_d | (wvalid & (wready === 1'b1));
            b_d = (bvalid === 1'b1);
            r = bresp;
            @(posedge ref_clk);
            if (aw_d) awvalid <= 1'b0;
            if (w_d) wvalid <= 1'b0;
            if (b_d) bready <= 1'b0;
            n++;
        end
        if (!b_d) chk_r(2'h3, 2'h0);
    endtask

    task automatic axi_rd(input logic [3:0] a, output logic [31:0] d,
                          output logic [1:0] r);
        int n;
        logic ar_d, r_d;
        n = 0;
        ar_d = 1'b0;
        r_d = 1'b0;
        @(posedge ref_clk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        while (!r_d && n < 40) begin
            @(negedge ref_clk);
            ar_d = ar_d | (arvalid & (arready === 1'b1));
            r_d = (rvalid === 1'b1);
            d = rdata;
            r = rresp;
            @(posedge ref_clk);
            if (ar_d) arvalid <= 1'b0;
            if (r_d) rready <= 1'b0;
            n++;
        end
        if (!r_d) chk_r(2'h3, 2'h0);
    endtask

    task automatic wr_ok(input logic [3:0] a, input logic [31:0] d);
        logic [1:0] r;
        axi_wr(a, d, r);
        chk_r(r, csf_pkg::RESP_OKAY);
    endtask

    task automatic rd_chk(input logic [3:0] a, input logic [31:0] exp);
        logic [31:0] d;
        logic [1:0] r;
        axi_rd(a, d, r);
        chk_w(d, exp);
        chk_r(r, csf_pkg::RESP_OKAY);
    endtask

    // Looks at the flag outputs once the launching edge has settled.
    task automatic st_chk(input logic [15:0] exp);
        @(negedge ref_clk);
        chk_w({16'h0000, status_word}, {16'h0000, exp});
    endtask

    // Watchdog sized well beyond the few hundred cycles the tests need.
    initial begin
        #400000;
        err_total++;
        tally_and_finish();
    end

    // Main sequence.
    initial begin
        {resetn, awvalid, wvalid, bready, arvalid, rready} = 6'h00;
        ce = 1'b1;
        wstrb = 4'hF;
        awaddr = 4'h0;
        araddr = 4'h0;
        wdata = 32'h0000_0000;
        repeat (6) @(posedge ref_clk);
        resetn <= 1'b1;
        st_chk(16'h0000);
        chk_w({27'h0, blocked, eff_level}, 32'h0000_0000);
        dp.op(4'hF, 16'h8000, 1'b1, 1'b1, 1'b0);
        st_chk(16'h000D);
        dp.op(4'h2, 16'h0000, 1'b0, 1'b0, 1'b0);
        st_chk(16'h000F);
        dp.op(4'h2, 16'h0000, 1'b0, 1'b0, 1'b1);
        st_chk(16'h000F);
        dp.op(4'h1, 16'h0001, 1'b0, 1'b1, 1'b0);
        st_chk(16'h000E);
        dp.op(4'h2, 16'h0001, 1'b1, 1'b0, 1'b1);
        st_chk(16'h000C);
        dp.op(4'hF, 16'h0005, 1'b0, 1'b0, 1'b0);
        st_chk(16'h0000);
        // Clock enable low: an offered operation must leave no trace.
        @(posedge ref_clk);
        ce <= 1'b0;
        dp.op(4'hF, 16'h8000, 1'b1, 1'b1, 1'b0);
        st_chk(16'h0000);
        @(posedge ref_clk);
        ce <= 1'b1;
        dp.set_rpt(1'b1);
        @(posedge ref_clk);
        st_chk(16'h0010);
        dp.set_rpt(1'b0);
        @(posedge ref_clk);
        st_chk(16'h0000);
        // Every priority level in turn; only seven blocks user interrupts.
        for (int i = 0; i < 8; i++) begin
            wr_ok(csf_pkg::OFS_STATUS, 32'(i) << 5);
            rd_chk(csf_pkg::OFS_STATUS, 32'(i) << 5);
            @(negedge ref_clk);
            chk_w({28'h0, eff_level}, 32'(i));
            chk_w({31'h0, blocked}, {31'h0, i == 7});
        end
        wr_ok(csf_pkg::OFS_STATUS, 32'h0000_0000);
        wr_ok(csf_pkg::OFS_CORE_CTRL, 32'h0000_0008);
        rd_chk(csf_pkg::OFS_EFF_LEVEL, 32'h0000_0018);
        wr_ok(csf_pkg::OFS_EFF_LEVEL, 32'h0000_0000);
        rd_chk(csf_pkg::OFS_EFF_LEVEL, 32'h0000_0018);
        wr_ok(csf_pkg::OFS_CORE_CTRL, 32'h0000_0000);
        rd_chk(csf_pkg::OFS_EFF_LEVEL, 32'h0000_0000);
        // With nesting off, software loses the field but hardware keeps it.
        wr_ok(csf_pkg::OFS_INT_CTRL1, 32'h0000_8000);
        rd_chk(csf_pkg::OFS_INT_CTRL1, 32'h0000_8000);
        wr_ok(csf_pkg::OFS_STATUS, 32'h0000_00A0);
        rd_chk(csf_pkg::OFS_STATUS, 32'h0000_0000);
        dp.load_ipl(3'h3);
        st_chk(16'h0060);
        wr_ok(csf_pkg::OFS_INT_CTRL1, 32'h0000_0000);
        wr_ok(csf_pkg::OFS_STATUS, 32'h0000_00A0);
        rd_chk(csf_pkg::OFS_STATUS, 32'h0000_00A0);
        // An unmapped word stores nothing and answers with an error.
        axi_wr(4'h2, 32'h0000_00E0, resp_v);
        chk_r(resp_v, csf_pkg::RESP_SLVERR);
        axi_rd(4'h2, data_v, resp_v);
        chk_w(data_v, 32'h0000_0000);
        chk_r(resp_v, csf_pkg::RESP_SLVERR);
        rd_chk(csf_pkg::OFS_STATUS, 32'h0000_00A0);
        // A reset in mid-run returns every flag and control bit to zero.
        wr_ok(csf_pkg::OFS_CORE_CTRL, 32'h0000_0008);
        @(posedge ref_clk);
        resetn <= 1'b0;
        repeat (2) @(posedge ref_clk);
        resetn <= 1'b1;
        st_chk(16'h0000);
        chk_w({27'h0, blocked, eff_level}, 32'h0000_0000);
        tally_and_finish();
    end
endmodule
